// ==== dcc_pkg.sv ====
// constants, field layout and state codes of the dma channel control block
// assumes a 32-bit apb slave with one aligned word per register
package dcc_pkg;
    localparam int          ADDR_W     = 12;
    localparam int          DATA_W     = 32;
    localparam int          EVT_W      = 4;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STAT_OFS   = 12'h004;
    localparam logic [11:0] MASK_OFS   = 12'h008;
    // control word fields
    localparam int          BUSY_BIT   = 15;
    localparam int          DIR_BIT    = 8;
    localparam int          ON_BIT     = 7;
    localparam int          EVOFF_BIT  = 6;
    localparam int          CHAIN_BIT  = 5;
    localparam int          AUTO_BIT   = 4;
    localparam int          SEEN_BIT   = 2;
    localparam int          PRIO_LSB   = 0;
    localparam int          PRIO_W     = 2;
    localparam logic [31:0] CTRL_RMASK = 32'h0000_81f7;
    // status and mask bit positions
    localparam int          EV_DONE    = 0;
    localparam int          EV_ABORT   = 1;
    localparam int          EV_CHAIN   = 2;
    localparam int          EV_DROP    = 3;
    // reset values
    localparam logic [1:0]  PRIO_RST   = 2'h0;
    localparam logic [3:0]  STAT_RST   = 4'h0;
    localparam logic [3:0]  MASK_RST   = 4'h0;
    localparam logic        FLAG_RST   = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_DRAIN = 2'b11
    } dcc_state_type;
endpackage

// ==== dcc_ctl_if.sv ====
// control and event signals between register file and channel sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dcc_ctl_if;
    logic on;
    logic evOff;
    logic chainAllow;
    logic dirSel;
    logic autoRe;
    logic startEvt;
    logic abortEvt;
    logic xferBusy;
    logic blockDone;
    logic nbrLowerDone;
    logic nbrHigherDone;
    logic setOn;
    logic clrOn;
    logic busy;
    logic seen;
    logic startGo;
    logic abortGo;
    logic chainHit;
    logic startDrop;
    logic doneEvt;

    modport regs (
        output on, evOff, chainAllow, dirSel, autoRe,
        output startEvt, abortEvt, xferBusy, blockDone, nbrLowerDone, nbrHigherDone,
        input  setOn, clrOn, busy, seen, startGo, abortGo, chainHit, startDrop, doneEvt
    );
    modport eng (
        input  on, evOff, chainAllow, dirSel, autoRe,
        input  startEvt, abortEvt, xferBusy, blockDone, nbrLowerDone, nbrHigherDone,
        output setOn, clrOn, busy, seen, startGo, abortGo, chainHit, startDrop, doneEvt
    );
endinterface

// ==== dcc_engine.sv ====
// channel sequencer: start, abort, block completion, suspend drain, chaining
// assumes config and datapath events arrive on ref_clk, reset already synchronised
`timescale 1ns/1ps
module dcc_engine (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstN,
    // control link
    dcc_ctl_if.eng   ctl
);
    typedef struct packed {
        dcc_pkg::dcc_state_type st;
        logic                   pend;
        logic                   seen;
    } dcc_eng_state_type;

    dcc_eng_state_type q;
    dcc_eng_state_type next_q;
    logic              accept;
    logic              startAcc;
    logic              abortAcc;
    logic              go;
    logic              done;
    logic              clr;
    logic              hit;

    always_comb begin
        next_q   = q;
        accept   = ctl.on | ctl.evOff;
        startAcc = ctl.startEvt & accept;
        abortAcc = ctl.abortEvt & accept;
        go       = 1'b0;
        done     = 1'b0;
        clr      = 1'b0;
        if (startAcc) begin
            next_q.pend = 1'b1;
        end
        case (q.st)
            dcc_pkg::ST_IDLE: begin
                if (ctl.on && (q.pend || startAcc) && !abortAcc) begin
                    next_q.st   = dcc_pkg::ST_RUN;
                    next_q.pend = 1'b0;
                    go          = 1'b1;
                end
            end
            dcc_pkg::ST_RUN: begin
                if (abortAcc) begin
                    next_q.st = dcc_pkg::ST_IDLE;
                end else if (ctl.blockDone) begin
                    next_q.st = dcc_pkg::ST_IDLE;
                    done      = 1'b1;
                    clr       = !ctl.autoRe;
                end else if (!ctl.on) begin
                    next_q.st = dcc_pkg::ST_DRAIN;
                end
            end
            dcc_pkg::ST_DRAIN: begin
                // suspend waits for the beat in flight to finish
                if (abortAcc) begin
                    next_q.st = dcc_pkg::ST_IDLE;
                end else if (ctl.blockDone) begin
                    next_q.st = dcc_pkg::ST_IDLE;
                    done      = 1'b1;
                    clr       = !ctl.autoRe;
                end else if (ctl.on) begin
                    next_q.st = dcc_pkg::ST_RUN;
                end else if (!ctl.xferBusy) begin
                    next_q.st = dcc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_q.st = dcc_pkg::ST_IDLE;
            end
        endcase
        if (abortAcc) begin
            next_q.pend = 1'b0;
            clr         = 1'b1;
        end
        // set wins over clear
        next_q.seen = (q.seen & !done) | startAcc | abortAcc;
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            q <= '{dcc_pkg::ST_IDLE, dcc_pkg::FLAG_RST, dcc_pkg::FLAG_RST};
        end else begin
            q <= next_q;
        end
    end

    // direction only matters once chaining is allowed
    assign hit           = ctl.chainAllow
                         & (ctl.dirSel ? ctl.nbrLowerDone : ctl.nbrHigherDone);
    assign ctl.chainHit  = hit;
    assign ctl.setOn     = hit;
    assign ctl.clrOn     = clr;
    assign ctl.startGo   = go;
    assign ctl.abortGo   = abortAcc;
    assign ctl.doneEvt   = done;
    assign ctl.startDrop = ctl.startEvt & !accept;
    assign ctl.seen      = q.seen;
    assign ctl.busy      = ctl.on | (q.st != dcc_pkg::ST_IDLE);
endmodule

// ==== dcc_top.sv ====
// dma channel control top: apb register file, interrupt status, sequencer
// assumes datapath events are synchronous to ref_clk and one cycle wide
`timescale 1ns/1ps
// Notes on behaviour
// - busy reads one while channel enabled or still active, else zero.
// - direction one chains from lower neighbour done, zero from higher neighbour.
// - direction bit has no effect while chaining is disallowed.
// - neighbour completion enables channel only when chaining is allowed.
// - clearing enable suspends only after current transaction finishes.
// - start and abort while off are taken only if events-when-off set.
// - without auto re-enable, block completion clears channel enable.
// - read-only event flag sets when a channel event is detected.
// - priority field codes 3..0 map directly to priorities 3..0.
// - unimplemented control bits 31-16, 14-9 and 3 read zero.
module dcc_top (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // datapath and neighbours
    input  wire logic        startEvt,
    input  wire logic        abortEvt,
    input  wire logic        xferBusy,
    input  wire logic        blockDone,
    input  wire logic        nbrLowerDone,
    input  wire logic        nbrHigherDone,
    // channel outputs
    output logic             chanOn,
    output logic             chanActive,
    output logic      [1:0]  chanPriority,
    output logic             xferStart,
    output logic             xferAbort,
    output logic             irq
);
    typedef struct packed {
        logic        on;
        logic        evOff;
        logic        chain;
        logic        dir;
        logic        autoRe;
        logic [1:0]  prio;
        logic [3:0]  stat;
        logic [3:0]  mask;
        logic        busy;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic        startOut;
        logic        abortOut;
        logic [31:0] prdata;
    } dcc_top_state_type;

    dcc_top_state_type q;
    dcc_top_state_type next_q;
    logic [1:0]        rstPipe;
    logic              rstN;
    logic              setup;
    logic              access;
    logic              wrCtrl;
    logic              wrStat;
    logic              wrMask;
    logic [31:0]       ctrlWord;
    logic [3:0]        evts;

    dcc_ctl_if ctl ();

    // reset release through two stages
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    assign ctl.on            = q.on;
    assign ctl.evOff         = q.evOff;
    assign ctl.chainAllow    = q.chain;
    assign ctl.dirSel        = q.dir;
    assign ctl.autoRe        = q.autoRe;
    assign ctl.startEvt      = startEvt;
    assign ctl.abortEvt      = abortEvt;
    assign ctl.xferBusy      = xferBusy;
    assign ctl.blockDone     = blockDone;
    assign ctl.nbrLowerDone  = nbrLowerDone;
    assign ctl.nbrHigherDone = nbrHigherDone;

    dcc_engine u_engine (
        .ref_clk (ref_clk),
        .rstN    (rstN),
        .ctl     (ctl.eng)
    );

    assign setup  = psel & !penable;
    assign access = psel & penable & q.pready;
    assign wrCtrl = access & pwrite & (paddr == dcc_pkg::CTRL_OFS);
    assign wrStat = access & pwrite & (paddr == dcc_pkg::STAT_OFS);
    assign wrMask = access & pwrite & (paddr == dcc_pkg::MASK_OFS);

    always_comb begin
        ctrlWord                     = '0;
        ctrlWord[dcc_pkg::BUSY_BIT]  = q.busy;
        ctrlWord[dcc_pkg::DIR_BIT]   = q.dir;
        ctrlWord[dcc_pkg::ON_BIT]    = q.on;
        ctrlWord[dcc_pkg::EVOFF_BIT] = q.evOff;
        ctrlWord[dcc_pkg::CHAIN_BIT] = q.chain;
        ctrlWord[dcc_pkg::AUTO_BIT]  = q.autoRe;
        ctrlWord[dcc_pkg::SEEN_BIT]  = ctl.seen;
        ctrlWord[dcc_pkg::PRIO_LSB +: dcc_pkg::PRIO_W] = q.prio;
    end

    assign evts = {ctl.startDrop, ctl.chainHit, ctl.abortGo, ctl.doneEvt};

    always_comb begin
        next_q          = q;
        next_q.pready   = 1'b0;
        next_q.startOut = ctl.startGo;
        next_q.abortOut = ctl.abortGo;
        next_q.busy     = ctl.busy;
        // read data is captured in the setup cycle; no wait state, pready rises in the first access cycle
        if (setup) begin
            next_q.pready  = 1'b1;
            next_q.pslverr = 1'b0;
            next_q.prdata  = '0;
            case (paddr)
                dcc_pkg::CTRL_OFS: next_q.prdata = pwrite ? '0 : ctrlWord;
                dcc_pkg::STAT_OFS: next_q.prdata = pwrite ? '0 : {28'h0, q.stat};
                dcc_pkg::MASK_OFS: next_q.prdata = pwrite ? '0 : {28'h0, q.mask};
                default:           next_q.pslverr = 1'b1;
            endcase
        end else if (access) begin
            next_q.pslverr = 1'b0;
            next_q.prdata  = '0;
        end
        if (wrCtrl) begin
            next_q.dir    = pwdata[dcc_pkg::DIR_BIT];
            next_q.evOff  = pwdata[dcc_pkg::EVOFF_BIT];
            next_q.chain  = pwdata[dcc_pkg::CHAIN_BIT];
            next_q.autoRe = pwdata[dcc_pkg::AUTO_BIT];
            next_q.prio   = pwdata[dcc_pkg::PRIO_LSB +: dcc_pkg::PRIO_W];
        end
        // chain set beats a simultaneous clear; a software write beats both
        if (wrCtrl) begin
            next_q.on = pwdata[dcc_pkg::ON_BIT];
        end else if (ctl.setOn) begin
            next_q.on = 1'b1;
        end else if (ctl.clrOn) begin
            next_q.on = 1'b0;
        end
        if (wrMask) begin
            next_q.mask = pwdata[3:0];
        end
        // write one to clear, a new event in the same cycle survives
        next_q.stat = (q.stat & ~(wrStat ? pwdata[3:0] : 4'h0)) | evts;
        next_q.irq  = |(next_q.stat & next_q.mask);
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign chanOn       = q.on;
    assign chanActive   = q.busy;
    assign chanPriority = q.prio;
    assign xferStart    = q.startOut;
    assign xferAbort    = q.abortOut;
    assign irq          = q.irq;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    property p_busy_on;
        q.on |=> q.busy;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy low while enabled");

    property p_busy_idle;
        (!q.on && !ctl.busy) |=> !q.busy;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("busy high when idle");

    property p_dir_low;
        (q.chain && q.dir && nbrLowerDone && !wrCtrl) |=> q.on;
    endproperty
    a_dir_low: assert property (p_dir_low) else $error("lower chain missed");

    property p_dir_high;
        (q.chain && !q.dir && nbrHigherDone && !wrCtrl) |=> q.on;
    endproperty
    a_dir_high: assert property (p_dir_high) else $error("higher chain missed");

    property p_dir_wrong;
        (q.chain && q.dir && !nbrLowerDone) |-> !ctl.setOn;
    endproperty
    a_dir_wrong: assert property (p_dir_wrong) else $error("chained from wrong side");

    property p_no_chain;
        (!q.on && !q.chain && !wrCtrl) |=> !q.on;
    endproperty
    a_no_chain: assert property (p_no_chain) else $error("enabled without chaining");

    property p_drain;
        ($fell(q.on) && ctl.busy && xferBusy && !blockDone && !abortEvt)
            |-> ##1 q.busy ##1 q.busy;
    endproperty
    a_drain: assert property (p_drain) else $error("suspend did not wait");

    property p_off_drop;
        (startEvt && !q.on && !q.evOff && !abortEvt) |=> !$rose(ctl.seen);
    endproperty
    a_off_drop: assert property (p_off_drop) else $error("event taken while off");

    property p_off_keep;
        (startEvt && !q.on && q.evOff) |=> ctl.seen;
    endproperty
    a_off_keep: assert property (p_off_keep) else $error("event lost while off");

    property p_auto;
        (q.autoRe && !ctl.abortGo) |-> !ctl.clrOn;
    endproperty
    a_auto: assert property (p_auto) else $error("auto channel was disabled");

    property p_reserved;
        (q.pready && paddr == dcc_pkg::CTRL_OFS) |-> ((q.prdata & ~dcc_pkg::CTRL_RMASK) == '0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_readback;
        wrCtrl |=> (q.prio == $past(pwdata[1:0])) && (q.chain == $past(pwdata[5]));
    endproperty
    a_readback: assert property (p_readback) else $error("field readback wrong");

    property p_irq;
        (|(q.stat & q.mask)) |-> q.irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    c_suspend: cover property ($fell(q.on) && xferBusy ##[1:40] !q.busy);
    c_chain:   cover property (ctl.setOn && !q.on ##1 q.on);
    c_auto:    cover property (ctl.doneEvt && q.autoRe ##1 q.on);
    c_offevt:  cover property (startEvt && !q.on && q.evOff ##[1:20] xferStart);
endmodule

// ==== test_dcc_top.sv ====
// self-checking bench for the dma channel control top, driven over apb
// assumes dcc_pkg, the control interface and the design modules are compiled first
`timescale 1ns/1ps
module test_dcc_top;
    localparam logic [11:0] A_CTL   = dcc_pkg::CTRL_OFS;
    localparam logic [11:0] A_STA   = dcc_pkg::STAT_OFS;
    localparam logic [11:0] A_MSK   = dcc_pkg::MASK_OFS;
    localparam logic [31:0] B_ON    = 32'h1 << dcc_pkg::ON_BIT;
    localparam logic [31:0] B_EVOFF = 32'h1 << dcc_pkg::EVOFF_BIT;
    localparam logic [31:0] B_CHAIN = 32'h1 << dcc_pkg::CHAIN_BIT;
    localparam logic [31:0] B_AUTO  = 32'h1 << dcc_pkg::AUTO_BIT;
    localparam logic [31:0] B_DIR   = 32'h1 << dcc_pkg::DIR_BIT;
    localparam logic [31:0] B_BUSY  = 32'h1 << dcc_pkg::BUSY_BIT;

    logic        ref_clk  = 1'b0;
    logic        arst_n   = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [4:0]  evVec    = 5'h00; // start, abort, done, lower, higher
    logic        xferBusy = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        chanOn;
    logic        chanActive;
    logic [1:0]  chanPriority;
    logic        xferStart;
    logic        xferAbort;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          testsRun   = 0;
    int          startCnt   = 0;
    int          abortCnt   = 0;
    int          expStart;

    dcc_top i_dut (
        .ref_clk       (ref_clk),
        .arst_n        (arst_n),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .startEvt      (evVec[0]),
        .abortEvt      (evVec[1]),
        .xferBusy      (xferBusy),
        .blockDone     (evVec[2]),
        .nbrLowerDone  (evVec[3]),
        .nbrHigherDone (evVec[4]),
        .chanOn        (chanOn),
        .chanActive    (chanActive),
        .chanPriority  (chanPriority),
        .xferStart     (xferStart),
        .xferAbort     (xferAbort),
        .irq           (irq)
    );

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // pulses last one cycle, so count them where they stand
    always @(posedge ref_clk) begin
        if (xferStart === 1'b1) startCnt++;
        if (xferAbort === 1'b1) abortCnt++;
    end

    task automatic endSim;
        $display("comparisons %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            mismatches++;
            $display("Error at %0t: no pready", $time);
            endSim();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdReg(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic evt(input int k);
        @(posedge ref_clk);
        evVec <= 5'h01 << k;
        @(posedge ref_clk);
        evVec <= 5'h00;
        idle(2);
    endtask

    initial begin
        #(40 * 50000);
        mismatches++;
        $display("Error at %0t: run timed out", $time);
        endSim();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        idle(3);
        rdReg(A_CTL);
        chkWord(rd, 32'h0000_0000, "ctrl after reset");
        chkBit(chanOn, 1'b0, "enable after reset");
        $display("test reset done");

        wr(A_CTL, 32'hffff_ffff);
        rdReg(A_CTL);
        chkWord(rd, 32'h0000_81f3, "ctrl all ones");
        for (int p = 0; p < 4; p++) begin
            wr(A_CTL, 32'(p));
            rdReg(A_CTL);
            chkWord(rd, 32'(p), "priority readback");
            chkWord({30'h0, chanPriority}, 32'(p), "priority port");
        end
        $display("test fields done");

        for (int a = 0; a < 2; a++) begin
            wr(A_STA, 32'h0000_000f);
            wr(A_CTL, B_ON | (a == 1 ? B_AUTO : 32'h0));
            expStart = startCnt + 1;
            evt(0);
            chkWord(32'(startCnt), 32'(expStart), "start launched");
            rdReg(A_CTL);
            chkBit(rd[dcc_pkg::SEEN_BIT], 1'b1, "event seen");
            evt(2);
            chkBit(chanOn, a == 1, "enable after block");
            rdReg(A_STA);
            chkWord(rd, 32'h0000_0001, "block done status");
            wr(A_CTL, 32'h0);
        end
        wr(A_CTL, B_ON);
        evt(0);
        evt(1);
        chkWord(32'(abortCnt), 32'h1, "abort accepted");
        chkBit(chanOn, 1'b0, "abort clears enable");
        $display("test start and block done");

        wr(A_CTL, B_ON);
        evt(0);
        @(posedge ref_clk);
        xferBusy <= 1'b1;
        wr(A_CTL, 32'h0);
        idle(1);
        chkBit(chanOn, 1'b0, "enable cleared");
        idle(4);
        chkBit(chanActive, 1'b1, "active while draining");
        rdReg(A_CTL);
        chkWord(rd & B_BUSY, B_BUSY, "busy while draining");
        @(posedge ref_clk);
        xferBusy <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            rdReg(A_CTL);
            if (rd[dcc_pkg::BUSY_BIT] === 1'b0) break;
        end
        chkBit(rd[dcc_pkg::BUSY_BIT], 1'b0, "busy after drain");
        chkBit(chanActive, 1'b0, "inactive after drain");
        $display("test suspend done");

        wr(A_STA, 32'h0000_000f);
        expStart = startCnt;
        evt(0);
        chkWord(32'(startCnt), 32'(expStart), "start while off");
        rdReg(A_STA);
        chkWord(rd, 32'h0000_0008, "dropped start status");
        chkBit(irq, 1'b0, "irq masked");
        wr(A_MSK, 32'h0000_0008);
        idle(2);
        chkBit(irq, 1'b1, "irq unmasked");
        wr(A_STA, 32'h0000_0008);
        idle(2);
        chkBit(irq, 1'b0, "irq cleared");
        wr(A_CTL, B_EVOFF);
        evt(0);
        chkWord(32'(startCnt), 32'(expStart), "held start");
        wr(A_CTL, B_EVOFF | B_ON);
        idle(3);
        chkWord(32'(startCnt), 32'(expStart + 1), "held start launched");
        wr(A_CTL, 32'h0);
        $display("test events while off done");

        for (int d = 0; d < 2; d++) begin
            wr(A_CTL, d == 1 ? B_DIR : 32'h0);
            evt(3);
            evt(4);
            chkBit(chanOn, 1'b0, "chain disallowed");
            wr(A_CTL, B_CHAIN | (d == 1 ? B_DIR : 32'h0));
            evt(d == 1 ? 4 : 3);
            chkBit(chanOn, 1'b0, "other neighbour");
            evt(d == 1 ? 3 : 4);
            chkBit(chanOn, 1'b1, "chained enable");
            wr(A_CTL, 32'h0);
        end
        $display("test chaining done");

        rdReg(12'h00c);
        chkBit(err, 1'b1, "unmapped error");
        chkWord(rd, 32'h0000_0000, "unmapped data");
        wr(12'h010, 32'hffff_ffff);
        rdReg(A_CTL);
        chkWord(rd, 32'h1 << dcc_pkg::SEEN_BIT, "ctrl untouched");
        $display("test unmapped done");
        endSim();
    end
endmodule
